// >>> tmc_timer_mode.v
// mode-control logic and counter of an 8-bit period timer
//
// Contract
// - mode[4:3]: 00 free-running, 01 one shot, 11 reserved.
// - in debug mode external trigger/reset edges are ignored and its level is held.
// - free 000: count while enabled, external signal unused.
// - free 001/010: count while enabled and signal high/low.
// - free 011/100/101: run while enabled; any/rise/fall edge resets.
// - free 110/111: low/high level holds counter reset.
// - one shot 000: start on enable; stop on disable or after match.
// - one shot 001/010/011: start on rise/fall/any edge once enabled.
// - one shot 100/101: rise/fall edge starts, later same edges reset.
// - one shot 110/111: rise/fall starts, low/high level resets.
// - monostable 001/010/011: edge start, stop at zero, enable kept.
// - level one shot 110/111: high/low starts, opposite level resets.
// - edge modes need a fresh edge after enable was cleared.
// - one shot: clock after match clears enable, count stops at zero.
// - external signal chosen by a per-timer source-select input.
`timescale 1ns/10ps
`default_nettype none
`include "tmc_consts.vh"
module tmc_timer_mode #(
  parameter SRC_W = 4,
  parameter CNT_W = 8
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [4:0] mode_i,
  input wire enable_set_i,
  input wire enable_clr_i,
  input wire [CNT_W-1:0] period_value_i,
  input wire [(1<<SRC_W)-1:0] ext_sources_i,
  input wire [SRC_W-1:0] ext_reset_source_select_i,
  input wire debug_i,
  output reg [CNT_W-1:0] count_value_o,
  output reg enable_o,
  output reg running_o,
  output reg match_o
);
  wire ext_trigger_reset_in;
  wire ers_rise;
  wire ers_fall;
  wire ers_lvl;
  reg [CNT_W-1:0] cnt_d;
  reg en_d;
  reg armed_q;
  reg armed_d;
  reg run;
  reg hold_rst;
  reg trig;
  reg edge_rst;
  reg one_shot;
  reg edge_start;
  wire [1:0] cls;
  wire [2:0] sub;
  wire en_now;
  wire at_match;
  wire rsvd;
  reg go;
  reg run_nxt;
  reg match_nxt;

  assign cls = mode_i[4:3];
  assign sub = mode_i[2:0];
  assign ext_trigger_reset_in =
    ext_sources_i[ext_reset_source_select_i];

  tmc_edge_det u_edge (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sig_i(ext_trigger_reset_in),
    .freeze_i(debug_i),
    .rise_o(ers_rise),
    .fall_o(ers_fall),
    .level_o(ers_lvl)
  );

  // software set (enable_set_i) beats the software clear (enable_clr_i) of the same cycle
  assign en_now = (enable_o && !enable_clr_i) || enable_set_i;
  assign at_match = (count_value_o == period_value_i);

  function edge_sel;
    input [1:0] kind;
    input r;
    input f;
    begin
      case (kind)
        `TMC_EDGE_RISE: edge_sel = r;
        `TMC_EDGE_FALL: edge_sel = f;
        `TMC_EDGE_ANY: edge_sel = r | f;
        default: edge_sel = 1'b0;
      endcase
    end
  endfunction

  // reserved codes never let the counter move, even if a start was
  // left armed by the mode used before
  function mode_rsvd;
    input [1:0] c;
    input [2:0] s;
    begin
      if (c == `TMC_CLS_RSVD) begin
        mode_rsvd = 1'b1;
      end else if (c == `TMC_CLS_MONO && s == `TMC_SUB_000) begin
        mode_rsvd = 1'b1;
      end else if (c == `TMC_CLS_MONO && s == `TMC_SUB_100) begin
        mode_rsvd = 1'b1;
      end else if (c == `TMC_CLS_MONO && s == `TMC_SUB_101) begin
        mode_rsvd = 1'b1;
      end else begin
        mode_rsvd = 1'b0;
      end
    end
  endfunction

  assign rsvd = mode_rsvd(cls, sub);

  always @* begin
    run = 1'b0;
    hold_rst = 1'b0;
    trig = 1'b0;
    edge_rst = 1'b0;
    one_shot = 1'b0;
    edge_start = 1'b0;
    case (cls)
      `TMC_CLS_FREE: begin
        case (sub)
          `TMC_SUB_000: run = en_now;
          `TMC_SUB_001: run = en_now && ers_lvl;
          `TMC_SUB_010: run = en_now && !ers_lvl;
          `TMC_SUB_011: edge_rst = ers_rise | ers_fall;
          `TMC_SUB_100: edge_rst = ers_rise;
          `TMC_SUB_101: edge_rst = ers_fall;
          `TMC_SUB_110: hold_rst = !ers_lvl;
          default: hold_rst = ers_lvl;
        endcase
        if (sub >= `TMC_SUB_011) begin
          run = en_now && !hold_rst;
        end
      end
      `TMC_CLS_ONESHOT: begin
        one_shot = 1'b1;
        case (sub)
          `TMC_SUB_000: trig = 1'b1;
          `TMC_SUB_001: begin
            edge_start = 1'b1;
            trig = edge_sel(`TMC_EDGE_RISE, ers_rise, ers_fall);
          end
          `TMC_SUB_010: begin
            edge_start = 1'b1;
            trig = edge_sel(`TMC_EDGE_FALL, ers_rise, ers_fall);
          end
          `TMC_SUB_011: begin
            edge_start = 1'b1;
            trig = edge_sel(`TMC_EDGE_ANY, ers_rise, ers_fall);
          end
          `TMC_SUB_100: begin
            edge_start = 1'b1;
            trig = ers_rise;
            edge_rst = armed_q && ers_rise;
          end
          `TMC_SUB_101: begin
            edge_start = 1'b1;
            trig = ers_fall;
            edge_rst = armed_q && ers_fall;
          end
          `TMC_SUB_110: begin
            edge_start = 1'b1;
            trig = ers_rise;
            hold_rst = armed_q && !ers_lvl;
          end
          default: begin
            edge_start = 1'b1;
            trig = ers_fall;
            hold_rst = armed_q && ers_lvl;
          end
        endcase
      end
      `TMC_CLS_MONO: begin
        case (sub)
          `TMC_SUB_001: begin
            edge_start = 1'b1;
            trig = edge_sel(`TMC_EDGE_RISE, ers_rise, ers_fall);
          end
          `TMC_SUB_010: begin
            edge_start = 1'b1;
            trig = edge_sel(`TMC_EDGE_FALL, ers_rise, ers_fall);
          end
          `TMC_SUB_011: begin
            edge_start = 1'b1;
            trig = edge_sel(`TMC_EDGE_ANY, ers_rise, ers_fall);
          end
          `TMC_SUB_110: begin
            one_shot = 1'b1;
            trig = ers_lvl;
            hold_rst = !ers_lvl;
          end
          `TMC_SUB_111: begin
            one_shot = 1'b1;
            trig = !ers_lvl;
            hold_rst = ers_lvl;
          end
          default: trig = 1'b0;
        endcase
      end
      default: trig = 1'b0;
    endcase
  end

  // final go decision; started classes count only once armed, except one shot 000
  always @* begin
    go = run;
    if (cls != `TMC_CLS_FREE) begin
      go = armed_q && en_now && !hold_rst;
      if (cls == `TMC_CLS_ONESHOT && !edge_start) begin
        go = en_now;
      end
    end
    if (rsvd) begin
      go = 1'b0;
    end
  end

  // armed once started; a cleared enable disarms so a new edge is needed
  always @* begin
    armed_d = armed_q;
    if (cls == `TMC_CLS_FREE) begin
      armed_d = 1'b0;
    end else if (!en_now) begin
      armed_d = 1'b0;
    end else if (trig && !armed_q) begin
      armed_d = 1'b1;
    end
    if (go && at_match && !hold_rst && !edge_rst) begin
      armed_d = 1'b0;
    end
  end

  always @* begin
    cnt_d = count_value_o;
    en_d = en_now;
    if (hold_rst || edge_rst) begin
      cnt_d = `TMC_CNT_RST;
    end else if (go) begin
      if (at_match) begin
        cnt_d = `TMC_CNT_RST;
        if (one_shot) begin
          // a software set in the completing cycle beats the hardware clear
          en_d = enable_set_i;
        end
      end else begin
        cnt_d = count_value_o + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @* begin
    run_nxt = go && !hold_rst;
    match_nxt = go && at_match;
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_value_o <= `TMC_CNT_RST;
      enable_o <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      count_value_o <= cnt_d;
      enable_o <= en_d;
      armed_q <= armed_d;
    end
  end

  // status flags describe the cycle that has just ended
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running_o <= 1'b0;
      match_o <= 1'b0;
    end else begin
      running_o <= run_nxt;
      match_o <= match_nxt;
    end
  end
endmodule // tmc_timer_mode
`default_nettype wire

// >>> tmc_consts.vh
// constants for the timer mode-control block
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH
`define TMC_CLS_FREE 2'h0
`define TMC_CLS_ONESHOT 2'h1
`define TMC_CLS_MONO 2'h2
`define TMC_CLS_RSVD 2'h3
`define TMC_SUB_000 3'h0
`define TMC_SUB_001 3'h1
`define TMC_SUB_010 3'h2
`define TMC_SUB_011 3'h3
`define TMC_SUB_100 3'h4
`define TMC_SUB_101 3'h5
`define TMC_SUB_110 3'h6
`define TMC_SUB_111 3'h7
`define TMC_EDGE_RISE 2'h1
`define TMC_EDGE_FALL 2'h2
`define TMC_EDGE_ANY 2'h3
`define TMC_CNT_RST 8'h00
`define TMC_PER_RST 8'hFF
`endif

// >>> tmc_edge_det.v
// edge detector for the external trigger/reset input
`timescale 1ns/10ps
`default_nettype none
module tmc_edge_det (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire sig_i,
  input wire freeze_i,
  output wire rise_o,
  output wire fall_o,
  output wire level_o
);
  reg prev_q;
  reg level_q;
  // edge history keeps tracking in debug, so a change made there
  // cannot turn into a false edge once debug ends
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      prev_q <= sig_i;
      if (!freeze_i) begin
        level_q <= sig_i;
      end
    end
  end
  assign rise_o = !freeze_i && sig_i && !prev_q;
  assign fall_o = !freeze_i && !sig_i && prev_q;
  assign level_o = freeze_i ? level_q : sig_i;
endmodule // tmc_edge_det
`default_nettype wire

// >>> tmc_timer_mode_props.sv
// assertions on the timer mode-control ports
`timescale 1ns/10ps
`default_nettype none
module tmc_timer_mode_chk #(
  parameter CNT_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] mode_i,
  input wire logic enable_set_i,
  input wire logic enable_clr_i,
  input wire logic [CNT_W-1:0] count_value_o,
  input wire logic enable_o,
  input wire logic running_o,
  input wire logic match_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wrap_zero_a: assert property (match_o |-> count_value_o == '0)
    else $error("match without zero count");
  count_step_a: assert property (
    $changed(count_value_o) && count_value_o != '0
    |-> count_value_o == $past(count_value_o) + 1'b1)
    else $error("count jumped");
  free_run_a: assert property (
    mode_i == 5'h00 && $past(mode_i) == 5'h00 && enable_o && $past(enable_o)
    |-> running_o)
    else $error("free mode not counting");
  enable_off_a: assert property (
    !enable_o && !$past(enable_o) |-> !running_o)
    else $error("counting while disabled");
  shot_clear_a: assert property (
    match_o && $past(mode_i[4:3]) == 2'h1 && !$past(enable_set_i)
    |-> !enable_o)
    else $error("one shot kept enable");
  shot_idle_a: assert property (
    $past(mode_i) == 5'h08 && !$past(enable_o) && !enable_o
    |-> $stable(count_value_o))
    else $error("idle one shot moved");
  rsvd_class_a: assert property (
    $past(mode_i[4:3]) == 2'h3 |-> $stable(count_value_o))
    else $error("reserved class counted");
  rsvd_mono_a: assert property (
    $past(mode_i) == 5'h10 |-> $stable(count_value_o))
    else $error("reserved sub-mode counted");
endmodule // tmc_timer_mode_chk
bind tmc_timer_mode tmc_timer_mode_chk #(.CNT_W(CNT_W)) u_chk (
  .core_clk_i, .rst_n_i, .mode_i, .enable_set_i, .enable_clr_i,
  .count_value_o, .enable_o, .running_o, .match_o);
`default_nettype wire

// >>> tmc_ers_model.sv
// model of the party driving the external trigger/reset line
`timescale 1ns/10ps
`default_nettype none
module tmc_ers_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic want_i,
  output var logic sig_o
);
  logic [2:0] gap_q;
  // a change waits six clocks after the last, so levels last at least six
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sig_o <= 1'b0;
      gap_q <= 3'h6;
    end else if (want_i != sig_o && gap_q == 3'h6) begin
      sig_o <= want_i;
      gap_q <= 3'h1;
    end else if (gap_q != 3'h6) begin
      gap_q <= gap_q + 3'h1;
    end
  end
endmodule // tmc_ers_model
`default_nettype wire

// >>> testbench.sv
// bench for the timer mode-control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] mode_i = 5'h00;
  logic set_i = 1'b0;
  logic clr_i = 1'b0;
  logic [7:0] per_i = 8'h02;
  logic dbg_i = 1'b0;
  logic want = 1'b0;
  logic ers;
  logic [7:0] cnt;
  logic en;
  logic mt;
  logic run_o;
  int errors = 0;
  int tests_run = 0;
  always #25 core_clk_i = ~core_clk_i;
  tmc_ers_model u_ers (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .want_i(want), .sig_o(ers));
  tmc_timer_mode DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .mode_i(mode_i), .enable_set_i(set_i), .enable_clr_i(clr_i),
    .period_value_i(per_i), .ext_sources_i({10'h000, ers, 5'h00}),
    .ext_reset_source_select_i(4'h5), .debug_i(dbg_i),
    .count_value_o(cnt), .enable_o(en), .running_o(run_o), .match_o(mt));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #5;
  endtask
  task en_set;
    set_i = 1'b1;
    tick(1);
    set_i = 1'b0;
  endtask
  task en_clr;
    clr_i = 1'b1;
    tick(1);
    clr_i = 1'b0;
  endtask
  task ext(input logic l);
    want = l;
    tick(8);
  endtask
  // reports whether the count moved over n clocks
  task mv(input string nm, input int n, input logic e);
    logic [7:0] v;
    v = cnt;
    tick(n);
    chk(nm, {7'h00, e}, {7'h00, cnt !== v});
  endtask
  task t_free;
    en_set;
    chk("cnt", 8'h01, cnt);
    tick(1);
    chk("cnt", 8'h02, cnt);
    tick(1);
    chk("cnt", 8'h00, cnt);
    chk("match", 8'h01, {7'h00, mt});
    chk("running", 8'h01, {7'h00, run_o});
    en_clr;
    mv("free hold", 4, 1'b0);
    chk("stopped", 8'h00, {7'h00, run_o});
    $display("t_free done");
  endtask
  task t_shot;
    mode_i = 5'h08;
    en_set;
    repeat (10) if (!mt) tick(1);
    chk("match", 8'h01, {7'h00, mt});
    chk("en", 8'h00, {7'h00, en});
    chk("cnt", 8'h00, cnt);
    mv("shot hold", 4, 1'b0);
    $display("t_shot done");
  endtask
  task t_rsvd;
    logic [4:0] m [4] = '{5'h18, 5'h1F, 5'h10, 5'h14};
    foreach (m[i]) begin
      mode_i = m[i];
      en_set;
      mv("rsvd", 5, 1'b0);
      en_clr;
    end
    $display("t_rsvd done");
  endtask
  task t_gate;
    mode_i = 5'h01;
    per_i = 8'hF0;
    en_set;
    mv("gate lo", 5, 1'b0);
    ext(1'b1);
    mv("gate hi", 4, 1'b1);
    en_clr;
    ext(1'b0);
    $display("t_gate done");
  endtask
  task t_edge;
    mode_i = 5'h09;
    en_set;
    mv("edge wait", 5, 1'b0);
    ext(1'b1);
    mv("edge run", 4, 1'b1);
    en_clr;
    ext(1'b0);
    en_set;
    mv("no fresh edge", 5, 1'b0);
    en_clr;
    $display("t_edge done");
  endtask
  task t_dbg;
    dbg_i = 1'b1;
    en_set;
    ext(1'b1);
    mv("dbg", 5, 1'b0);
    ext(1'b0);
    dbg_i = 1'b0;
    mv("dbg off", 5, 1'b0);
    en_clr;
    $display("t_dbg done");
  endtask
  task t_limit;
    mode_i = 5'h04;
    per_i = 8'hF0;
    en_set;
    tick(2);
    ext(1'b1);
    chk("edge reset", 8'h06, cnt);
    en_clr;
    mode_i = 5'h11;
    per_i = 8'h09;
    ext(1'b0);
    en_set;
    ext(1'b1);
    chk("mono cnt", 8'h00, cnt);
    chk("mono en", 8'h01, {7'h00, en});
    mv("mono rearm", 4, 1'b0);
    en_clr;
    $display("t_limit done");
  endtask
  task test_done;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    test_done;
  end
  initial begin
    tick(3);
    rst_n_i = 1'b1;
    tick(1);
    t_free;
    t_shot;
    t_rsvd;
    t_gate;
    t_edge;
    t_dbg;
    t_limit;
    test_done;
  end
endmodule // testbench
`default_nettype wire
